// ---- include/dpw_pkg.sv ----
// Shared constants and types for the dimming PWM unit
package dpw_pkg;
    // Clocking
    localparam int         CLK_HZ      = 20_000_000;
    localparam int         REF_TICK_HZ = 1_000_000;
    localparam int         ALT_SLOW_HZ = 8_000_000;
    localparam logic [4:0] REF_DIV_M1  = 5'(CLK_HZ / REF_TICK_HZ - 1);
    localparam logic [4:0] SLOW_NUM    = 5'(ALT_SLOW_HZ / REF_TICK_HZ);
    localparam logic [4:0] SLOW_DEN    = 5'(CLK_HZ / REF_TICK_HZ);
    // Sizes
    localparam int N_CH   = 16;
    localparam int N_TMR  = 8;
    localparam int CNT_W  = 20;
    localparam int DIV_W  = 18;
    localparam int LIM_W  = 5;
    localparam int DUTY_W = 25;
    localparam int FD_W   = 10;
    localparam int PH_W   = 22;
    localparam int TC_W   = 26;
    // Timer reset values and limits
    localparam logic [DIV_W-1:0] DIV_ONE = 18'h00100;
    localparam logic [LIM_W-1:0] LIM_MAX = 5'h14;
    localparam logic [LIM_W-1:0] LIM_RST = 5'h0a;
    // Byte addresses
    localparam logic [11:0] TMR_BASE     = 12'h100;
    localparam logic [11:0] GLB_CONF_OFS = 12'h140;
    // Word index inside a channel's 16-byte slot
    localparam logic [1:0] CH_PHASE_IDX = 2'h0;
    localparam logic [1:0] CH_DUTY_IDX  = 2'h1;
    localparam logic [1:0] CH_FADE_IDX  = 2'h2;
    localparam logic [1:0] CH_DCUR_IDX  = 2'h3;
    // Word index inside a timer's 8-byte slot
    localparam logic TMR_CONF_IDX = 1'b0;
    // Field positions
    localparam int PH_SEL_LSB   = 20;
    localparam int FD_INC_BIT   = 0;
    localparam int FD_START_BIT = 1;
    localparam int FD_NUM_LSB   = 2;
    localparam int FD_CYC_LSB   = 12;
    localparam int FD_SCL_LSB   = 22;
    localparam int TC_LIM_LSB   = 18;
    localparam int TC_SRC_BIT   = 23;
    localparam int TC_PAUSE_BIT = 24;
    localparam int TC_RST_BIT   = 25;
    localparam int TC_UPD_BIT   = 26;
    localparam int GLB_SLOW_BIT = 0;

    typedef enum logic {
        FD_IDLE = 1'b0,
        FD_RUN  = 1'b1
    } dpw_fade_e;
endpackage : dpw_pkg

// ---- include/dpw_tbus_if.sv ----
// Count and overflow of one timer, shared with the channels
`timescale 1ns/1ns
`default_nettype none
interface dpw_tbus_if;
    logic [19:0] cnt;
    logic        ovf;
    modport drv  (output cnt, output ovf);
    modport sink (input cnt, input ovf);
endinterface : dpw_tbus_if
`default_nettype wire

// ---- src/dpw_timer.sv ----
// One timer: fractional divider and 20-bit counter
`timescale 1ns/1ns
`default_nettype none
module dpw_timer (
    // Clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // Control
    input  wire logic                           src_en,
    input  wire logic                           glitch_free,
    input  wire logic [dpw_pkg::DIV_W-1:0]      cfg_div,
    input  wire logic [dpw_pkg::LIM_W-1:0]      cfg_lim,
    input  wire logic                           pause,
    input  wire logic                           cnt_rst,
    input  wire logic                           para_up,
    // Count out
    dpw_tbus_if.drv                             tb
);
    import dpw_pkg::*;

    typedef struct packed {
        logic [DIV_W:0]   acc;
        logic [CNT_W-1:0] cnt;
        logic [DIV_W-1:0] div_a;
        logic [LIM_W-1:0] lim_a;
        logic             ovf;
    } dpw_tmr_s;

    dpw_tmr_s s_r;
    dpw_tmr_s s_nxt;

    function automatic logic [CNT_W-1:0] lim_mask(input logic [LIM_W-1:0] lim);
        logic [LIM_W-1:0] l;
        l = (lim > LIM_MAX) ? LIM_MAX : lim;
        return CNT_W'((21'h1 << l) - 21'h1);
    endfunction : lim_mask

    always_comb begin
        logic [DIV_W:0]   sum;
        logic [DIV_W-1:0] dv;
        s_nxt     = s_r;
        s_nxt.ovf = 1'b0;
        // Divisors under 1.0 behave as 1.0
        dv  = (s_r.div_a < DIV_ONE) ? DIV_ONE : s_r.div_a;
        sum = s_r.acc + {1'b0, DIV_ONE};
        if (cnt_rst) begin
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
            if (glitch_free) begin
                s_nxt.div_a = cfg_div;
                s_nxt.lim_a = cfg_lim;
            end
        end else if (src_en && !pause) begin
            if (sum >= {1'b0, dv}) begin
                s_nxt.acc = sum - {1'b0, dv};
                if (s_r.cnt >= lim_mask(s_r.lim_a)) begin
                    s_nxt.cnt = '0;
                    s_nxt.ovf = 1'b1;
                    if (glitch_free) begin
                        s_nxt.div_a = cfg_div;
                        s_nxt.lim_a = cfg_lim;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 20'h1;
                end
            end else begin
                s_nxt.acc = sum;
            end
        end
        if (!glitch_free && para_up) begin
            s_nxt.div_a = cfg_div;
            s_nxt.lim_a = cfg_lim;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{acc: '0, cnt: '0, div_a: DIV_ONE, lim_a: LIM_RST, ovf: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tb.cnt = s_r.cnt;
    assign tb.ovf = s_r.ovf;
endmodule : dpw_timer
`default_nettype wire

// ---- src/dpw_chan.sv ----
// One PWM channel: phase compare, dithering and fade engine
`timescale 1ns/1ns
`default_nettype none
module dpw_chan (
    // Clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // Selected timer
    input  wire logic [dpw_pkg::CNT_W-1:0]       cnt,
    input  wire logic                            ovf,
    // Configuration
    input  wire logic [dpw_pkg::CNT_W-1:0]       phase,
    input  wire logic                            duty_wr,
    input  wire logic [dpw_pkg::DUTY_W-1:0]      duty_wdata,
    input  wire logic                            fade_go,
    input  wire logic                            fade_inc,
    input  wire logic [dpw_pkg::FD_W-1:0]        fade_num,
    input  wire logic [dpw_pkg::FD_W-1:0]        fade_cycle,
    input  wire logic [dpw_pkg::FD_W-1:0]        fade_scale,
    // Results
    output logic                                 pwm,
    output logic [dpw_pkg::DUTY_W-1:0]           duty_cur,
    output logic                                 fading,
    output logic                                 done
);
    import dpw_pkg::*;

    typedef struct packed {
        dpw_fade_e         st;
        logic              pwm;
        logic [DUTY_W-1:0] duty;
        logic [3:0]        dith;
        logic              ext;
        logic [FD_W-1:0]   cyc;
        logic [FD_W-1:0]   steps;
        logic              done;
    } dpw_ch_s;

    dpw_ch_s s_r;
    dpw_ch_s s_nxt;

    always_comb begin
        logic [CNT_W-1:0] lo_pt;
        logic [4:0]       dsum;
        logic [21:0]      stepv;
        logic [FD_W-1:0]  cyc_lim;
        logic [FD_W-1:0]  num_lim;
        stepv      = '0;
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        // Low point, stretched by one count when the dither carry is due
        lo_pt = CNT_W'({1'b0, phase} + s_r.duty[24:4] + {20'h0, s_r.ext});
        if (cnt == phase) begin
            s_nxt.pwm = 1'b1;
        end
        if (cnt == lo_pt) begin
            s_nxt.pwm = 1'b0;
        end
        dsum = {1'b0, s_r.dith} + {1'b0, s_r.duty[3:0]};
        if (ovf) begin
            s_nxt.dith = dsum[3:0];
            s_nxt.ext  = dsum[4];
        end
        cyc_lim = (fade_cycle == '0) ? 10'h001 : fade_cycle;
        num_lim = (fade_num == '0) ? 10'h001 : fade_num;
        if (fade_inc) begin
            stepv = {1'b0, s_r.duty[24:4]} + {12'h000, fade_scale};
            if (stepv[21]) begin
                stepv = 22'h1fffff;
            end
        end else begin
            stepv = {1'b0, s_r.duty[24:4]} - {12'h000, fade_scale};
            if (stepv[21]) begin
                stepv = 22'h000000;
            end
        end
        case (s_r.st)
            FD_IDLE: begin
                if (fade_go) begin
                    s_nxt.st    = FD_RUN;
                    s_nxt.cyc   = '0;
                    s_nxt.steps = '0;
                end
            end
            FD_RUN: begin
                if (ovf) begin
                    if ({1'b0, s_r.cyc} + 11'h001 >= {1'b0, cyc_lim}) begin
                        s_nxt.cyc        = '0;
                        s_nxt.duty[24:4] = stepv[20:0];
                        s_nxt.steps      = s_r.steps + 10'h001;
                        if ({1'b0, s_r.steps} + 11'h001 >= {1'b0, num_lim}) begin
                            s_nxt.st   = FD_IDLE;
                            s_nxt.done = 1'b1;
                        end
                    end else begin
                        s_nxt.cyc = s_r.cyc + 10'h001;
                    end
                end
            end
            default: begin
                s_nxt.st = FD_IDLE;
            end
        endcase
        // A software load of the duty wins over a fade step
        if (duty_wr) begin
            s_nxt.duty = duty_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pwm      = s_r.pwm;
    assign duty_cur = s_r.duty;
    assign fading   = (s_r.st == FD_RUN);
    assign done     = s_r.done;
endmodule : dpw_chan
`default_nettype wire

// ---- src/dpw_top.sv ----
// Dimming PWM unit: APB register file, eight timers and sixteen channels
// Behaviour
// - Sixteen independent PWM outputs: eight fast, eight slow channels.
// - Four timers per group; each channel uses one timer of its group.
// - Fast timer source: bus clock when select set, reference tick otherwise.
// - Divisor is fixed point: ten integer bits, eight fraction bits.
// - Divided clock drives 20-bit counter; at limit it wraps and flags overflow.
// - Software can reset, pause and read each timer counter.
// - Period equals divisor times two to the limit over source rate.
// - Slow timers use reference tick or slow clock; slow clock is selectable.
// - Fast timers take new limit and divisor at next overflow or on counter reset.
// - Slow timers take new limit and divisor only on update strobe.
// - Output goes high when count equals the phase point.
// - Output goes low at phase point plus integer duty.
// - Four duty fraction bits stretch pulses by one count at that rate.
// - Fade start changes duty automatically, up or down by direction bit.
// - Fade adds or subtracts step size every programmed number of periods.
// - Fade ends after the programmed number of steps.
// - Finished fade raises that channel's event.
// - Each timer raises its own overflow event.
// - Current duty is readable and follows the fade.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dpw_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // PWM outputs and events
    output logic      [15:0] pwm_out,
    output logic      [15:0] fade_done_irq,
    output logic      [3:0]  fast_timer_overflow_irq,
    output logic      [3:0]  slow_timer_overflow_irq
);
    import dpw_pkg::*;

    typedef struct packed {
        logic [31:0]                  rdata;
        logic                         slverr;
        logic                         rdy;
        logic [4:0]                   ref_cnt;
        logic                         ref_en;
        logic [4:0]                   slow_acc;
        logic                         slow_en;
        logic                         slow_sel;
        logic [N_CH-1:0][PH_W-1:0]    phase;
        logic [N_CH-1:0][31:0]        fade;
        logic [N_CH-1:0][DUTY_W-1:0]  duty;
        logic [N_CH-1:0]              duty_wr;
        logic [N_CH-1:0]              fade_go;
        logic [N_TMR-1:0][TC_W-1:0]   tconf;
        logic [N_TMR-1:0]             tupd;
    } dpw_top_s;

    dpw_top_s s_r;
    dpw_top_s s_nxt;

    logic [N_TMR-1:0][CNT_W-1:0]  tcnt;
    logic [N_TMR-1:0]             tovf;
    logic [N_CH-1:0][DUTY_W-1:0]  dcur;
    logic [N_CH-1:0]              fading;
    logic [N_CH-1:0]              pwm_w;
    logic [N_CH-1:0]              done_w;

    function automatic logic mapped(input logic [11:0] a);
        return (a[1:0] == 2'h0) && ((a < TMR_BASE) || (a <= GLB_CONF_OFS));
    endfunction : mapped

    always_comb begin
        logic [3:0] ci;
        logic [2:0] ti;
        logic       wr_go;
        ci    = paddr[7:4];
        ti    = paddr[5:3];
        wr_go = psel && penable && pwrite && mapped(paddr);
        s_nxt         = s_r;
        s_nxt.rdy     = 1'b1;
        s_nxt.duty_wr = '0;
        s_nxt.fade_go = '0;
        s_nxt.tupd    = '0;
        // Reference tick enable
        if (s_r.ref_cnt == REF_DIV_M1) begin
            s_nxt.ref_cnt = '0;
            s_nxt.ref_en  = 1'b1;
        end else begin
            s_nxt.ref_cnt = s_r.ref_cnt + 5'h01;
            s_nxt.ref_en  = 1'b0;
        end
        // Alternate slow clock as a rate-accumulated enable
        if (s_r.slow_acc + SLOW_NUM >= SLOW_DEN) begin
            s_nxt.slow_acc = s_r.slow_acc + SLOW_NUM - SLOW_DEN;
            s_nxt.slow_en  = 1'b1;
        end else begin
            s_nxt.slow_acc = s_r.slow_acc + SLOW_NUM;
            s_nxt.slow_en  = 1'b0;
        end
        // Read data prepared in the setup phase
        if (psel && !penable) begin
            s_nxt.slverr = !mapped(paddr);
            s_nxt.rdata  = '0;
            if (mapped(paddr)) begin
                if (paddr < TMR_BASE) begin
                    case (paddr[3:2])
                        CH_PHASE_IDX: s_nxt.rdata = {10'h000, s_r.phase[ci]};
                        CH_DUTY_IDX:  s_nxt.rdata = {7'h00, s_r.duty[ci]};
                        CH_FADE_IDX: begin
                            s_nxt.rdata = s_r.fade[ci];
                            s_nxt.rdata[FD_START_BIT] = fading[ci];
                        end
                        default:      s_nxt.rdata = {7'h00, dcur[ci]};
                    endcase
                end else if (paddr == GLB_CONF_OFS) begin
                    s_nxt.rdata = {31'h0, s_r.slow_sel};
                end else if (paddr[2] == TMR_CONF_IDX) begin
                    s_nxt.rdata = {6'h00, s_r.tconf[ti]};
                end else begin
                    s_nxt.rdata = {12'h000, tcnt[ti]};
                end
            end
        end
        // Writes take effect at the access edge
        if (wr_go) begin
            if (paddr < TMR_BASE) begin
                case (paddr[3:2])
                    CH_PHASE_IDX: s_nxt.phase[ci] = pwdata[PH_W-1:0];
                    CH_DUTY_IDX: begin
                        s_nxt.duty[ci]    = pwdata[DUTY_W-1:0];
                        s_nxt.duty_wr[ci] = 1'b1;
                    end
                    CH_FADE_IDX: begin
                        s_nxt.fade[ci]               = pwdata;
                        s_nxt.fade[ci][FD_START_BIT] = 1'b0;
                        s_nxt.fade_go[ci]            = pwdata[FD_START_BIT];
                    end
                    default: ;
                endcase
            end else if (paddr == GLB_CONF_OFS) begin
                s_nxt.slow_sel = pwdata[GLB_SLOW_BIT];
            end else if (paddr[2] == TMR_CONF_IDX) begin
                s_nxt.tconf[ti] = pwdata[TC_W-1:0];
                s_nxt.tupd[ti]  = pwdata[TC_UPD_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Timers 0..3 serve the fast group, 4..7 the slow group
    for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
        logic src_en;
        dpw_tbus_if tb();
        if (t < 4) begin : g_fast
            assign src_en = s_r.tconf[t][TC_SRC_BIT] ? 1'b1 : s_r.ref_en;
        end else begin : g_slow
            assign src_en = s_r.tconf[t][TC_SRC_BIT] ?
                            (s_r.slow_sel ? 1'b1 : s_r.slow_en) : s_r.ref_en;
        end
        dpw_timer u_tmr (
            .pclk        (pclk),
            .presetn     (presetn),
            .src_en      (src_en),
            .glitch_free (t < 4),
            .cfg_div     (s_r.tconf[t][DIV_W-1:0]),
            .cfg_lim     (s_r.tconf[t][TC_LIM_LSB +: LIM_W]),
            .pause       (s_r.tconf[t][TC_PAUSE_BIT]),
            .cnt_rst     (s_r.tconf[t][TC_RST_BIT]),
            .para_up     (s_r.tupd[t]),
            .tb          (tb.drv)
        );
        assign tcnt[t] = tb.cnt;
        assign tovf[t] = tb.ovf;
    end

    // Channels 0..7 fast, 8..15 slow; each picks a timer inside its group
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        logic [2:0] tidx;
        assign tidx = {1'(c / 8), s_r.phase[c][PH_SEL_LSB +: 2]};
        dpw_chan u_ch (
            .pclk       (pclk),
            .presetn    (presetn),
            .cnt        (tcnt[tidx]),
            .ovf        (tovf[tidx]),
            .phase      (s_r.phase[c][CNT_W-1:0]),
            .duty_wr    (s_r.duty_wr[c]),
            .duty_wdata (s_r.duty[c]),
            .fade_go    (s_r.fade_go[c]),
            .fade_inc   (s_r.fade[c][FD_INC_BIT]),
            .fade_num   (s_r.fade[c][FD_NUM_LSB +: FD_W]),
            .fade_cycle (s_r.fade[c][FD_CYC_LSB +: FD_W]),
            .fade_scale (s_r.fade[c][FD_SCL_LSB +: FD_W]),
            .pwm        (pwm_w[c]),
            .duty_cur   (dcur[c]),
            .fading     (fading[c]),
            .done       (done_w[c])
        );
    end

    assign prdata                  = s_r.rdata;
    assign pready                  = s_r.rdy;
    assign pslverr                 = s_r.slverr;
    assign pwm_out                 = pwm_w;
    assign fade_done_irq           = done_w;
    assign fast_timer_overflow_irq = tovf[3:0];
    assign slow_timer_overflow_irq = tovf[7:4];
endmodule : dpw_top
`default_nettype wire

// ---- bench/dpw_top_monitor.sv ----
// Port-level checks of the dimming PWM unit
`timescale 1ns/1ns
`default_nettype none
module dpw_top_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events
    input wire logic [15:0] fade_done_irq,
    input wire logic [3:0]  fast_timer_overflow_irq,
    input wire logic [3:0]  slow_timer_overflow_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_always: assert property ($past(presetn) |-> pready)
        else $error("pready low");
    a_misalign_err: assert property (s_setup ##0 paddr[1:0] != 2'h0 |=> pslverr && prdata == 0)
        else $error("misaligned access not refused");
    a_read_stands: assert property (s_setup ##1 s_access |=> $stable(prdata))
        else $error("read data moved");
    a_fast_ovf_pulse: assert property (|fast_timer_overflow_irq |=>
        (fast_timer_overflow_irq & $past(fast_timer_overflow_irq)) == 4'h0) else $error("fast ovf");
    a_slow_ovf_pulse: assert property (|slow_timer_overflow_irq |=>
        (slow_timer_overflow_irq & $past(slow_timer_overflow_irq)) == 4'h0) else $error("slow ovf");
    a_done_one_cycle: assert property (|fade_done_irq |=>
        (fade_done_irq & $past(fade_done_irq)) == 16'h0) else $error("fade done too long");
    a_fast_done_cause: assert property (|fade_done_irq[7:0] |->
        |(fast_timer_overflow_irq | $past(fast_timer_overflow_irq)
        | $past(fast_timer_overflow_irq, 2))) else $error("fast fade end off period");
    a_slow_done_cause: assert property (|fade_done_irq[15:8] |->
        |(slow_timer_overflow_irq | $past(slow_timer_overflow_irq)
        | $past(slow_timer_overflow_irq, 2))) else $error("slow fade end off period");
endmodule : dpw_top_monitor
bind dpw_top dpw_top_monitor dpw_top_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fade_done_irq(fade_done_irq), .fast_timer_overflow_irq(fast_timer_overflow_irq),
    .slow_timer_overflow_irq(slow_timer_overflow_irq));
`default_nettype wire

// ---- bench/dpw_load.sv ----
// Load model: counts cycles in which the chosen PWM line drives its load
`timescale 1ns/1ns
`default_nettype none
module dpw_load (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // PWM lines and selection
    input  wire logic [15:0] pwm,
    input  wire logic [3:0]  sel,
    // On-time so far
    output logic      [15:0] hi
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi <= 16'h0;
        end else if (pwm[sel]) begin
            hi <= hi + 16'h1;
        end
    end
endmodule : dpw_load
`default_nettype wire

// ---- bench/dimming_pwm_controller_bench.sv ----
// Self-checking bench for the dimming PWM unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module dimming_pwm_controller_bench;
    import dpw_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic [15:0] pwm_out, fade_done_irq, load_hi;
    logic [3:0] fovf, sovf;
    wire logic [7:0] ovf = {sovf, fovf};
    int mismatches = 0, checked = 0;
    time tp, tl;
    initial begin
        forever #25 pclk = ~pclk;
    end
    dpw_top dpw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out), .fade_done_irq(fade_done_irq),
        .fast_timer_overflow_irq(fovf), .slow_timer_overflow_irq(sovf));
    dpw_load dpw_load_inst (.pclk(pclk), .presetn(presetn), .pwm(pwm_out), .sel(4'h0),
        .hi(load_hi));
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            mismatches++;
            end_of_test();
        end
    endtask : apb
    // Timer word: b = {update, reset, pause, source}
    function automatic logic [31:0] cf(input logic [4:0] l, input logic [3:0] b,
                                       input logic [17:0] d = DIV_ONE);
        return {5'h00, b, l, d};
    endfunction : cf
    task automatic wt(input int t, input int n = 2);
        int k;
        repeat (n) begin
            for (k = 0; k < 4000; k++) begin
                @(negedge pclk);
                if (ovf[t] === 1'b1) break;
            end
            tp = tl;
            tl = $time;
            if (k == 4000) begin
                mismatches++;
                end_of_test();
            end
        end
    endtask : wt
    task automatic t_regs;
        apb(1'b0, TMR_BASE, 32'h0);
        `CHK("timer conf reset", 32'h0, rd)
        apb(1'b1, 12'h010, 32'h0012_3456);
        apb(1'b1, 12'h012, 32'hffff_ffff);
        `CHK("misaligned err", 1'b1, er)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("phase and select", 32'h0012_3456, rd)
        apb(1'b0, 12'h204, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        $display("test regs done");
    endtask : t_regs
    task automatic t_fast;
        logic [31:0] c;
        apb(1'b1, TMR_BASE, cf(5'h3, 4'b0101));
        apb(1'b1, TMR_BASE, cf(5'h3, 4'b0001));
        wt(0);
        `CHK("period", 64'd8, (tl - tp) / 50)
        apb(1'b1, TMR_BASE, cf(5'h4, 4'b0001));
        wt(0, 1);
        `CHK("old period", 64'd8, (tl - tp) / 50)
        wt(0, 1);
        `CHK("new period", 64'd16, (tl - tp) / 50)
        apb(1'b1, TMR_BASE + 12'h8, cf(5'h3, 4'b0101, 18'h00180));
        apb(1'b1, TMR_BASE + 12'h8, cf(5'h3, 4'b0001, 18'h00180));
        wt(1);
        `CHK("frac period", 64'd12, (tl - tp) / 50)
        apb(1'b1, TMR_BASE + 12'h10, cf(5'h1, 4'b0100));
        apb(1'b1, TMR_BASE + 12'h10, cf(5'h1, 4'b0000));
        wt(2);
        `CHK("ref tick period", 64'd40, (tl - tp) / 50)
        apb(1'b1, TMR_BASE, cf(5'h4, 4'b0011));
        apb(1'b0, TMR_BASE + 12'h4, 32'h0);
        c = rd;
        apb(1'b0, TMR_BASE + 12'h4, 32'h0);
        `CHK("paused count", c, rd)
        apb(1'b1, TMR_BASE, cf(5'h4, 4'b0101));
        apb(1'b0, TMR_BASE + 12'h4, 32'h0);
        `CHK("held count", 32'h0, rd)
        apb(1'b1, TMR_BASE, cf(5'h4, 4'b0001));
        $display("test fast timers done");
    endtask : t_fast
    task automatic t_slow;
        apb(1'b1, GLB_CONF_OFS, 32'h1);
        apb(1'b1, TMR_BASE + 12'h20, cf(5'h2, 4'b1001));
        wt(4);
        `CHK("slow period", 64'd4, (tl - tp) / 50)
        apb(1'b1, TMR_BASE + 12'h20, cf(5'h3, 4'b0001));
        wt(4);
        `CHK("no update", 64'd4, (tl - tp) / 50)
        apb(1'b1, TMR_BASE + 12'h20, cf(5'h3, 4'b1001));
        wt(4);
        `CHK("updated", 64'd8, (tl - tp) / 50)
        apb(1'b1, GLB_CONF_OFS, 32'h0);
        wt(4);
        `CHK("8 MHz period", 64'd20, (tl - tp) / 50)
        $display("test slow timers done");
    endtask : t_slow
    task automatic t_duty;
        logic [31:0] dv [3] = '{32'h50, 32'h58, 32'h0};
        logic [15:0] hx [3] = '{16'd80, 16'd88, 16'd0};
        logic [15:0] h;
        apb(1'b1, 12'h000, 32'h2);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h004, dv[i]);
            wt(0);
            h = load_hi;
            wt(0, 16);
            `CHK("on cycles", hx[i], 16'(load_hi - h))
        end
        $display("test duty done");
    endtask : t_duty
    task automatic t_fade;
        logic [11:0] b [2] = '{12'h000, 12'h080};
        logic [31:0] d0 [2] = '{32'h20, 32'h80};
        logic [31:0] fw [2] = '{32'h0080_100f, 32'h00c0_100a};
        logic [31:0] dx [2] = '{32'h80, 32'h20};
        int k;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, b[i] + 12'h4, d0[i]);
            apb(1'b1, b[i] + 12'h8, fw[i]);
            apb(1'b0, b[i] + 12'h8, 32'h0);
            `CHK("fade running", 1'b1, rd[1])
            for (k = 0; k < 2000; k++) begin
                @(negedge pclk);
                if (fade_done_irq[b[i][7:4]] === 1'b1) break;
            end
            `CHK("fade end", 1'b1, k < 2000)
            if (k == 2000) end_of_test();
            apb(1'b0, b[i] + 12'hc, 32'h0);
            `CHK("duty after fade", dx[i], rd)
        end
        $display("test fade done");
    endtask : t_fade
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_fast();
        t_slow();
        t_duty();
        t_fade();
        end_of_test();
    end
endmodule : dimming_pwm_controller_bench
`default_nettype wire
